// File: hmc_top.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Halt-mode standby controller with an APB register port
module hmc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        halt_exec,
   input  wire logic        int_pending,
   input  wire logic        int_ack_en,
   input  wire logic        dma_active,
   input  wire logic        wdt_standby_run_bit,
   input  wire logic        wdt_enable_bit,
   input  wire logic [7:0]  port_d,
   output logic             cpu_clk_en,
   output logic             fast_internal_osc_clock_en,
   output logic             crystal_osc_clock_en,
   output logic             ext_clock_en,
   output logic             slow_internal_osc_clock_en,
   output logic             flash_stop,
   output logic             ram_stop,
   output logic [7:0]       port_q,
   output logic             periph_run,
   output logic             crc_ram_en,
   output logic             guard_en,
   output logic             halted,
   output logic             resume_pulse,
   output logic             vector_take
);
   hmc_pkg::hmc_state_t state_reg;
   hmc_pkg::hmc_state_t state_next;
   logic [hmc_pkg::CNT_W-1:0] cnt_reg;
   logic [hmc_pkg::CNT_W-1:0] cnt_next;
   logic [3:0] ctrl_reg;
   logic       vec_reg;
   logic       irq_sync;

   // Interrupt request comes from another block's timing; synchronise it
   hmc_sync3 u_irq_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (int_pending),
      .q       (irq_sync)
   );

   // Entry is blocked by a pending unmasked request, whatever clock runs
   wire enter_ok = halt_exec && !irq_sync;
   wire wake_req = (state_reg == hmc_pkg::HMC_HALT) && irq_sync;
   wire [hmc_pkg::CNT_W-1:0] wait_len = int_ack_en ?
      hmc_pkg::CNT_W'(hmc_pkg::REL_VEC_CYC) :
      hmc_pkg::CNT_W'(hmc_pkg::REL_NOVEC_CYC);

   // Next-state logic for the halt sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         hmc_pkg::HMC_RUN: begin
            if (enter_ok) begin
               state_next = hmc_pkg::HMC_HALT;
            end
         end
         hmc_pkg::HMC_HALT: begin
            if (wake_req) begin
               state_next = hmc_pkg::HMC_WAKE;
               cnt_next   = wait_len - 1'b1;
            end
         end
         hmc_pkg::HMC_WAKE: begin
            if (cnt_reg == '0) begin
               state_next = hmc_pkg::HMC_RUN;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: state_next = hmc_pkg::HMC_RUN;
      endcase
   end

   // Reset leaves any state for run; the CPU then fetches the reset vector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= hmc_pkg::HMC_RUN;
         cnt_reg   <= '0;
         vec_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         if (wake_req) begin
            vec_reg <= int_ack_en;
         end
      end
   end

   // Single halted flag; wake wait still keeps the CPU stopped
   wire halt_flag = (state_next != hmc_pkg::HMC_RUN);
   wire done_now  = (state_reg == hmc_pkg::HMC_WAKE) && (cnt_reg == '0);

   // Clock source enables: the active source never stops in halt
   // Software setting of the fast oscillator; halt may only add to it
   wire hoco_next = ctrl_reg[hmc_pkg::CTRL_HOCO_BIT];
   wire sel_hoco  = ctrl_reg[hmc_pkg::CTRL_FIR_BIT] == 1'b0;

   // Outputs are registered straight from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halted                     <= 1'b0;
         cpu_clk_en                 <= 1'b1;
         flash_stop                 <= 1'b0;
         ram_stop                   <= 1'b0;
         fast_internal_osc_clock_en <= 1'b1;
         crystal_osc_clock_en       <= 1'b0;
         ext_clock_en               <= 1'b0;
         slow_internal_osc_clock_en <= 1'b0;
         port_q                     <= 8'h00;
         periph_run                 <= 1'b1;
         crc_ram_en                 <= 1'b1;
         guard_en                   <= 1'b1;
         resume_pulse               <= 1'b0;
         vector_take                <= 1'b0;
      end else begin
         halted     <= halt_flag;
         cpu_clk_en <= !halt_flag;
         flash_stop <= halt_flag;
         ram_stop   <= halt_flag;
         // In halt the selected source is forced on; others as software left them
         fast_internal_osc_clock_en <= hoco_next | (halt_flag & sel_hoco);
         crystal_osc_clock_en <= ctrl_reg[hmc_pkg::CTRL_XOSC_BIT]
                                 | (halt_flag & !sel_hoco
                                    & !ctrl_reg[hmc_pkg::CTRL_EXT_BIT]);
         ext_clock_en <= ctrl_reg[hmc_pkg::CTRL_EXT_BIT];
         // Slow oscillator follows watchdog enable; in halt the standby run bit must also be set
         slow_internal_osc_clock_en <= wdt_enable_bit & (wdt_standby_run_bit | !halt_flag);
         if (!halt_flag) begin
            port_q <= port_d;
         end
         periph_run   <= 1'b1;
         crc_ram_en   <= !halt_flag | dma_active;
         guard_en     <= !halt_flag | dma_active;
         resume_pulse <= done_now;
         vector_take  <= done_now & vec_reg;
      end
   end

   // APB decode: zero wait state, error on unmapped address
   wire acc      = psel && penable;
   wire hit_ctrl = (paddr == hmc_pkg::CTRL_OFS);
   wire hit_stat = (paddr == hmc_pkg::STATUS_OFS);
   wire hit_opt  = (paddr == hmc_pkg::OPT_OFS);
   wire mapped   = hit_ctrl || hit_stat || hit_opt;
   wire [31:0] rd_mux = hit_ctrl ? {28'h0000000, ctrl_reg} :
                        hit_stat ? {28'h0000000, vec_reg, cnt_reg == '0, halted,
                                    state_reg == hmc_pkg::HMC_WAKE} :
                        hit_opt  ? {27'h0000000, wdt_enable_bit, 3'h0, wdt_standby_run_bit} :
                                   32'h00000000;

   // Clock control writes are refused while halted, so the source cannot stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= hmc_pkg::CTRL_RST;
         pready   <= 1'b0;
         prdata   <= 32'h00000000;
         pslverr  <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
         if (acc && pready && pwrite && hit_ctrl && pstrb[0] && !halted) begin
            ctrl_reg <= pwdata[3:0];
         end
      end
   end
endmodule

// File: hmc_pkg.sv
// Overview of operation
// - Halt instruction enters halted state unless blocked
// - Entry accepted from either main clock source
// - Pending unmasked interrupt blocks halt entry
// - CPU clock gated off while halted
// - Active main clock kept running, unstoppable
// - Slow oscillator follows watchdog option bits
// - CPU, flash, RAM stopped automatically
// - Port latches hold values while halted
// - Peripherals keep working while halted
// - CRC over RAM only during DMA
// - RAM/SFR guards, parity only during DMA
// - Two release causes: interrupt and reset
// - Vectored service or next instruction resume
// - Release takes 15-16 or 9-10 clocks
// - Reset ends halt, starts at vector
package hmc_pkg;
   // Release waits counted in main clocks, lower end of printed range
   localparam int unsigned REL_VEC_CYC   = 15;
   localparam int unsigned REL_NOVEC_CYC = 9;
   localparam int unsigned CNT_W         = 5;
   // Register map over APB
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] OPT_OFS    = 12'h008;
   // Field positions
   localparam int unsigned CTRL_FIR_BIT   = 0;
   localparam int unsigned CTRL_HOCO_BIT  = 1;
   localparam int unsigned CTRL_XOSC_BIT  = 2;
   localparam int unsigned CTRL_EXT_BIT   = 3;
   localparam int unsigned OPT_STBY_BIT   = 0;
   localparam int unsigned OPT_WDTEN_BIT  = 4;
   // Reset values
   localparam logic [3:0] CTRL_RST = 4'h2;
   localparam logic [7:0] OPT_RST  = 8'h00;
   typedef enum logic [1:0] {HMC_RUN, HMC_HALT, HMC_WAKE} hmc_state_t;
endpackage

// File: hmc_sync3.sv
`timescale 1ns/1ns
// Three-stage synchroniser; a change counts once stages two and three agree
module hmc_sync3 (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic d,
   output logic      q
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   // First stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         q      <= 1'b0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q <= s3_reg;
         end
      end
   end
endmodule

// File: hmc_chk.sv
`timescale 1ns/1ns
module hmc_chk (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       halted,
   input wire logic       cpu_clk_en,
   input wire logic       flash_stop,
   input wire logic       ram_stop,
   input wire logic [7:0] port_q,
   input wire logic       periph_run,
   input wire logic       crc_ram_en,
   input wire logic       guard_en,
   input wire logic       dma_active,
   input wire logic       resume_pulse,
   input wire logic       fast_internal_osc_clock_en,
   input wire logic       crystal_osc_clock_en,
   input wire logic       ext_clock_en,
   input wire logic       slow_internal_osc_clock_en,
   input wire logic       wdt_standby_run_bit,
   input wire logic       wdt_enable_bit,
   input wire logic       vector_take
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Two halted cycles in a row: latches must not move
   sequence s_held; halted ##1 halted; endsequence
   sequence s_idle_dma; (halted && !dma_active)[*3]; endsequence
   property p_gate; halted |-> !cpu_clk_en; endproperty
   property p_stop; halted |-> flash_stop && ram_stop; endproperty
   property p_port; s_held |-> $stable(port_q); endproperty
   property p_main; halted |-> fast_internal_osc_clock_en || crystal_osc_clock_en
      || ext_clock_en; endproperty
   property p_dma; s_idle_dma |-> periph_run && !crc_ram_en && !guard_en; endproperty
   // Option bits alone set the slow oscillator while halted
   property p_slow; halted |-> slow_internal_osc_clock_en
      == $past(wdt_enable_bit && wdt_standby_run_bit); endproperty
   property p_vec; vector_take |-> resume_pulse; endproperty
   // Resume comes with the CPU clock just back on, after it was off one and eight clocks before
   property p_lat; resume_pulse |-> cpu_clk_en && !$past(cpu_clk_en)
      && !$past(cpu_clk_en, 8); endproperty
   a_gate: assert property (p_gate) else $error("cpu clock on while halted");
   a_stop: assert property (p_stop) else $error("memories run while halted");
   a_port: assert property (p_port) else $error("port latch moved");
   a_main: assert property (p_main) else $error("main clock stopped");
   a_dma: assert property (p_dma) else $error("guard or crc active without dma");
   a_slow: assert property (p_slow) else $error("slow osc follows halt");
   a_vec: assert property (p_vec) else $error("vector without resume");
   a_lat: assert property (p_lat) else $error("release wait wrong");
endmodule
bind hmc_top hmc_chk hmc_chk_i (.*);

// File: hmc_cpu_mdl.sv
`timescale 1ns/1ns
// Core side: halt pulse and combined unmasked request, one flop each
module hmc_cpu_mdl (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic halt_req,
   input  wire logic irq,
   output logic      halt_exec,
   output logic      int_pending
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_exec <= 1'b0;
         int_pending <= 1'b0;
      end else begin
         halt_exec <= halt_req;
         int_pending <= irq;
      end
   end
endmodule

// File: hmc_tb_top.sv
`timescale 1ns/1ns
module hmc_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, halt_req, irq, int_ack_en;
   logic halt_exec, int_pending, cpu_clk_en, halted, resume_pulse, vector_take, e;
   logic dma, wdt_run, wdt_en, fosc_en, xosc_en, eosc_en, sosc_en;
   logic flash_stop, ram_stop, periph_run, crc_ram_en, guard_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [7:0] port_d, port_q;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   hmc_cpu_mdl hmc_cpu_mdl_i (.pclk(pclk), .presetn(presetn), .halt_req(halt_req), .irq(irq),
      .halt_exec(halt_exec), .int_pending(int_pending));
   hmc_top hmc_top_i (
      .pclk                       (pclk),
      .presetn                    (presetn),
      .psel                       (psel),
      .penable                    (penable),
      .pwrite                     (pwrite),
      .paddr                      (paddr),
      .pwdata                     (pwdata),
      .pstrb                      (4'hF),
      .pready                     (pready),
      .prdata                     (prdata),
      .pslverr                    (pslverr),
      .halt_exec                  (halt_exec),
      .int_pending                (int_pending),
      .int_ack_en                 (int_ack_en),
      .dma_active                 (dma),
      .wdt_standby_run_bit        (wdt_run),
      .wdt_enable_bit             (wdt_en),
      .port_d                     (port_d),
      .cpu_clk_en                 (cpu_clk_en),
      .fast_internal_osc_clock_en (fosc_en),
      .crystal_osc_clock_en       (xosc_en),
      .ext_clock_en               (eosc_en),
      .slow_internal_osc_clock_en (sosc_en),
      .flash_stop                 (flash_stop),
      .ram_stop                   (ram_stop),
      .port_q                     (port_q),
      .periph_run                 (periph_run),
      .crc_ram_en                 (crc_ram_en),
      .guard_en                   (guard_en),
      .halted                     (halted),
      .resume_pulse               (resume_pulse),
      .vector_take                (vector_take)
   );
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) if (++cyc > 3000) begin error_cnt++; report_and_stop(); end
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin error_cnt++; $display("BAD %0t seen %h exp %h", $time, s, x); end
   endtask
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk); penable <= 1;
      @(posedge pclk); while (pready !== 1'b1) @(posedge pclk);
      r = prdata; e = pslverr; psel <= 0; penable <= 0;
   endtask
   task pulse_halt; @(posedge pclk); halt_req <= 1; @(posedge pclk); halt_req <= 0; endtask
   task t_halt(input logic ack, input logic xtal);
      int n;
      int_ack_en <= ack; wdt_run <= ack; port_d <= 8'hA5;
      pulse_halt(); repeat (4) @(posedge pclk);
      chk(halted, 1);
      chk(cpu_clk_en, 0);
      chk({flash_stop, ram_stop}, 2'b11);
      chk(periph_run, 1);
      chk(crc_ram_en, 0);
      chk(guard_en, 0);
      chk({fosc_en, xosc_en}, {!xtal, xtal});
      chk(sosc_en, ack);
      dma <= 1; port_d <= 8'h5A; repeat (2) @(posedge pclk); chk(port_q, 8'hA5);
      chk(crc_ram_en, 1);
      chk(guard_en, 1);
      dma <= 0; irq <= 1; n = 0;
      while (resume_pulse !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
      chk(vector_take, ack);
      chk(n >= (ack ? 15 : 9) + 3 && n <= (ack ? 16 : 10) + 6, 1);
      irq <= 0; repeat (8) @(posedge pclk);
      chk(cpu_clk_en, 1);
      $display("halt test done ack=%0d", ack);
   endtask
   initial begin
      {psel, penable, pwrite, halt_req, irq, int_ack_en, dma, wdt_run, wdt_en} = 0;
      paddr = 0; pwdata = 0; port_d = 0; presetn = 0;
      repeat (3) @(posedge pclk); presetn <= 1;
      apb(0, hmc_pkg::CTRL_OFS, 0); chk(r[3:0], hmc_pkg::CTRL_RST);
      apb(0, hmc_pkg::OPT_OFS, 0); chk(r[7:0], hmc_pkg::OPT_RST);
      apb(0, 12'h0FC, 0); chk(e, 1);
      apb(0, hmc_pkg::STATUS_OFS, 0); chk(r[3:0], 4'h4);
      wdt_en <= 1; apb(0, hmc_pkg::OPT_OFS, 0); chk(r[7:0], 8'h10);
      t_halt(1, 0); t_halt(0, 0);
      // Crystal selected and fast oscillator stopped by software first
      apb(1, hmc_pkg::CTRL_OFS, 32'h0000_0005);
      apb(0, hmc_pkg::CTRL_OFS, 0); chk(r[3:0], 4'h5);
      t_halt(1, 1);
      apb(0, hmc_pkg::STATUS_OFS, 0); chk(r[3:0], 4'hC);
      irq <= 1; repeat (6) @(posedge pclk); pulse_halt(); repeat (4) @(posedge pclk);
      chk(halted, 0);
      irq <= 0; repeat (8) @(posedge pclk); pulse_halt(); repeat (4) @(posedge pclk);
      chk(halted, 1);
      presetn <= 0; @(posedge pclk); @(posedge pclk);
      chk(halted, 0);
      chk(cpu_clk_en, 1);
      presetn <= 1; repeat (2) @(posedge pclk);
      chk(halted, 0);
      chk(cpu_clk_en, 1);
      $display("reset test done");
      report_and_stop();
   end
endmodule
